// [oled_serial_write_port_test.sv]
// Self-checking bench: host and device ends joined by one link, plus a
// second device driven directly by the bench to break framing on purpose.
`timescale 1ns/1ps
`default_nettype none

module oled_serial_write_port_test;
    import osw_pkg::*;
    typedef struct packed {
        logic fw;
        logic dc;
        logic [7:0] b;
        logic [2:0] pg;
        logic [6:0] col;
    } osw_row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tx_valid = 1'b0;
    logic tx_dc = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic four_wire = 1'b1;
    logic panel_rst = 1'b0;
    logic [6:0] pix_x = 7'h00;
    logic [5:0] pix_y = 6'h00;
    logic tx_ready, pixel, cmd_valid, wr_valid, d2_cmd_valid, busy;
    logic [7:0] cmd_byte, wr_data, d2_cmd_byte;
    logic [9:0] wr_addr;
    logic [2:0] page, pg;
    logic [6:0] col, cl;
    int err_total = 0;
    int total_checks = 0;
    int wr_cnt = 0;
    int d2_cnt = 0;
    int acc, c0, n;
    osw_row_t r;
    // Expected page and column after each byte; column wraps inside a page
    osw_row_t rows [11] = '{
        {1'b1, 1'b0, 8'hb3, 3'h3, 7'h00}, {1'b1, 1'b0, 8'h05, 3'h3, 7'h05},
        {1'b0, 1'b0, 8'h12, 3'h3, 7'h25}, {1'b1, 1'b1, 8'ha5, 3'h3, 7'h26},
        {1'b0, 1'b1, 8'h3c, 3'h3, 7'h27}, {1'b0, 1'b0, 8'hb7, 3'h7, 7'h27},
        {1'b1, 1'b0, 8'h0f, 3'h7, 7'h2f}, {1'b1, 1'b0, 8'h17, 3'h7, 7'h7f},
        {1'b1, 1'b1, 8'h81, 3'h7, 7'h00}, {1'b0, 1'b1, 8'hff, 3'h7, 7'h01},
        {1'b1, 1'b0, 8'haf, 3'h7, 7'h01}};

    osw_link_if lnk();
    osw_link_if lnk2();

    always #2 clk = ~clk;

    osw_host osw_host_inst (.I_CLOCK(clk), .I_RST_N(rst_n), .I_TX_VALID(tx_valid),
        .O_TX_READY(tx_ready), .I_TX_DC(tx_dc), .I_TX_BYTE(tx_byte),
        .I_FOUR_WIRE(four_wire), .I_PANEL_RST(panel_rst), .O_BUSY(busy), .LNK(lnk));
    osw_dev osw_dev_inst (.I_CLOCK(clk), .I_RST_N(rst_n), .I_FOUR_WIRE(four_wire),
        .I_PIX_X(pix_x), .I_PIX_Y(pix_y), .O_PIXEL(pixel), .O_CMD_VALID(cmd_valid),
        .O_CMD_BYTE(cmd_byte), .O_WR_VALID(wr_valid), .O_WR_ADDR(wr_addr),
        .O_WR_DATA(wr_data), .O_PAGE(page), .O_COL(col), .LNK(lnk));
    // Second device sees only what the bench bit-bangs
    osw_dev osw_dev_inst_b (.I_CLOCK(clk), .I_RST_N(rst_n), .I_FOUR_WIRE(1'b1),
        .I_PIX_X(7'h00), .I_PIX_Y(6'h00), .O_PIXEL(), .O_CMD_VALID(d2_cmd_valid),
        .O_CMD_BYTE(d2_cmd_byte), .O_WR_VALID(), .O_WR_ADDR(), .O_WR_DATA(),
        .O_PAGE(), .O_COL(), .LNK(lnk2));
    osw_link_monitor osw_link_monitor_inst (.I_CLOCK(clk), .I_RST_N(rst_n),
        .I_FOUR_WIRE(four_wire), .I_PANEL_RST(panel_rst), .cs_n(lnk.cs_n),
        .sclk(lnk.sclk), .serial_data_in(lnk.serial_data_in), .dc(lnk.dc),
        .res_n(lnk.res_n));

    // Strobes are one clock wide, so count them at every falling edge
    always @(negedge clk) begin
        wr_cnt <= wr_cnt + int'(wr_valid === 1'b1);
        d2_cnt <= d2_cnt + int'(d2_cmd_valid === 1'b1);
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Offer one word and hold it until the FIFO has room
    task automatic send(input logic d, input logic [7:0] b);
        @(negedge clk);
        tx_valid = 1'b1;
        tx_dc = d;
        tx_byte = b;
        while (tx_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        tx_valid = 1'b0;
    endtask

    task automatic wait_strobe;
        n = 0;
        while (cmd_valid !== 1'b1 && wr_valid !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic pix(input logic [6:0] x, input logic [5:0] y, input logic e);
        @(negedge clk);
        pix_x = x;
        pix_y = y;
        repeat (2) @(negedge clk);
        chk(pixel, e);
    endtask

    // One bench-made bit: data set while low, 16 ns low then 16 ns high
    task automatic bang(input logic b);
        lnk2.serial_data_in = b;
        repeat (4) @(negedge clk);
        lnk2.sclk = 1'b1;
        repeat (4) @(negedge clk);
        lnk2.sclk = 1'b0;
    endtask

    initial begin
        #100000;
        err_total++;
        summarize();
    end

    initial begin
        lnk2.cs_n = 1'b1;
        lnk2.sclk = 1'b0;
        lnk2.serial_data_in = 1'b0;
        lnk2.dc = 1'b0;
        lnk2.res_n = 1'b1;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        pg = 3'h0;
        cl = 7'h00;
        foreach (rows[i]) begin
            r = rows[i];
            four_wire = r.fw;
            send(r.dc, r.b);
            wait_strobe();
            chk(busy, 1'b1);
            chk(cmd_valid, !r.dc);
            chk(wr_valid, r.dc);
            chk(r.dc ? wr_addr : cmd_byte, r.dc ? {pg, cl} : r.b);
            if (r.dc)
                chk(wr_data, r.b);
            repeat (12) @(negedge clk);
            chk(busy, 1'b0);
            chk(page, r.pg);
            chk(col, r.col);
            pg = r.pg;
            cl = r.col;
        end
        // Stored columns read back bit by bit, rows of page 3 and two pixels of page 7
        for (int k = 0; k < 8; k++)
            pix(7'h25, 6'(24 + k), rows[3].b[k]);
        pix(7'h7f, 6'h3f, 1'b1);
        pix(7'h00, 6'h38, 1'b1);
        // Fill the FIFO back to back until it refuses, then let it drain
        c0 = wr_cnt;
        acc = 0;
        tx_dc = 1'b1;
        tx_byte = 8'h40;
        tx_valid = 1'b1;
        while (tx_ready === 1'b1 && acc < 20) begin
            @(negedge clk);
            acc++;
            tx_byte = 8'h40 + 8'(acc);
        end
        tx_valid = 1'b0;
        chk(16'(acc >= 8 && acc < 20), 16'h1);
        n = 0;
        while (wr_cnt < c0 + acc && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk(16'(wr_cnt - c0), 16'(acc));
        chk(wr_data, 8'h40 + 8'(acc - 1));
        chk(wr_addr, {3'h7, 7'(acc)});
        // Panel reset clears the pointers
        panel_rst = 1'b1;
        repeat (3) @(negedge clk);
        panel_rst = 1'b0;
        repeat (8) @(negedge clk);
        chk(page, 3'h0);
        chk(col, 7'h00);
        // Clocks while deselected and a cut-short frame must give nothing
        for (int k = 7; k >= 0; k--)
            bang(1'b1);
        lnk2.cs_n = 1'b0;
        for (int k = 0; k < 4; k++)
            bang(1'b0);
        lnk2.cs_n = 1'b1;
        lnk2.serial_data_in = 1'b1;
        repeat (12) @(negedge clk);
        chk(16'(d2_cnt), 16'h0);
        // Flag pin says data until the last bit, so only a late sample sees a command
        lnk2.cs_n = 1'b0;
        for (int k = 7; k >= 0; k--) begin
            lnk2.dc = (k != 0);
            bang(((8'hb5 >> k) & 8'h01) != 8'h00);
        end
        repeat (4) @(negedge clk);
        lnk2.cs_n = 1'b1;
        lnk2.serial_data_in = ~lnk2.serial_data_in;
        lnk2.dc = 1'b1;
        repeat (12) @(negedge clk);
        chk(16'(d2_cnt), 16'h1);
        chk(d2_cmd_byte, 8'hb5);
        // Reset in mid-run returns the link to idle
        rst_n = 1'b0;
        @(negedge clk);
        chk({lnk.cs_n, lnk.sclk, lnk.res_n, tx_ready}, 4'hb);
        chk({cmd_valid, wr_valid, page, col}, 12'h000);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        summarize();
    end
endmodule
`default_nettype wire

// [osw_dev.sv]
// Device end: receives command and data bytes and writes display memory.
// Assumes the link pins are asynchronous to I_CLOCK and change slowly
// enough (half period of many clocks) for two-stage sampling.
`timescale 1ns/1ps
`default_nettype none
`include "osw_map.svh"

module osw_dev
    import osw_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_FOUR_WIRE,
    input wire logic [6:0] I_PIX_X,
    input wire logic [5:0] I_PIX_Y,
    output logic O_PIXEL,
    output logic O_CMD_VALID,
    output logic [7:0] O_CMD_BYTE,
    output logic O_WR_VALID,
    output logic [9:0] O_WR_ADDR,
    output logic [7:0] O_WR_DATA,
    output logic [2:0] O_PAGE,
    output logic [6:0] O_COL,
    osw_link_if.dev LNK
);

    // ********************************************
    // Input synchronisers
    // ********************************************

    // Order: 0 sclk, 1 serial data, 2 cs_n, 3 dc, 4 res_n, 5 mode strap
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;

    assign raw = {I_FOUR_WIRE, LNK.res_n, LNK.dc, LNK.cs_n, LNK.serial_data_in, LNK.sclk};

    // Two stages per pin; reset values match the idle pin levels
    generate
        for (genvar g = 0; g < NSYNC; g++) begin : g_sync
            localparam logic IDLE_LVL = (g == 2 || g == 4);
            always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    meta_r[g] <= IDLE_LVL;
                    sync_r[g] <= IDLE_LVL;
                end else begin
                    meta_r[g] <= raw[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    logic sclk_s;
    logic ser_in_s;
    logic cs_n_s;
    logic dc_s;
    logic res_n_s;
    logic four_s;

    assign sclk_s = sync_r[0];
    assign ser_in_s = sync_r[1];
    assign cs_n_s = sync_r[2];
    assign dc_s = sync_r[3];
    assign res_n_s = sync_r[4];
    assign four_s = sync_r[5];

    // ********************************************
    // Serial clock edge detect
    // ********************************************

    logic sclk_d_r;
    logic rise;

    // Previous synchronised level, reset low like an idle clock
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) sclk_d_r <= 1'b0;
        else sclk_d_r <= sclk_s;
    end

    // Only rising edges inside a selected frame count
    assign rise = sclk_s && !sclk_d_r && !cs_n_s && res_n_s;

    // ********************************************
    // Shifter and bit counter
    // ********************************************

    logic [7:0] sh_r;
    logic [3:0] cnt_r;
    logic last_bit;
    logic [7:0] byte_nxt;
    logic flag_nxt;

    // 4-wire bytes are 8 bits, 3-wire frames add the flag bit
    assign last_bit = (cnt_r == (four_s ? `OSW_BYTE_BITS : `OSW_BITS_3W) - 4'h1);

    // Newest bit lands in the LSB, so the first bit ends as the MSB
    assign byte_nxt = {sh_r[6:0], ser_in_s};

    // In 3-wire the flag sits just above the byte; in 4-wire the pin is
    // taken with the last bit, so a pin change after the byte is harmless
    assign flag_nxt = four_s ? dc_s : sh_r[7];

    // Deselect or panel reset drops any partial byte
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cnt_r <= 4'h0;
        end else if (cs_n_s || !res_n_s) begin
            cnt_r <= 4'h0;
        end else if (rise) begin
            cnt_r <= last_bit ? 4'h0 : cnt_r + 4'h1;
        end
    end

    // Shift register; content is don't-care between frames
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) sh_r <= 8'h00;
        else if (rise) sh_r <= byte_nxt;
    end

    // ********************************************
    // Byte dispatch
    // ********************************************

    logic byte_done;
    logic is_cmd;
    logic is_data;

    assign byte_done = rise && last_bit;
    assign is_cmd = byte_done && !flag_nxt;
    assign is_data = byte_done && flag_nxt;

    // Command strobe for the controller core
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CMD_VALID <= 1'b0;
            O_CMD_BYTE <= 8'h00;
        end else begin
            O_CMD_VALID <= is_cmd;
            if (is_cmd) O_CMD_BYTE <= byte_nxt;
        end
    end

    // ********************************************
    // Page and column pointers
    // ********************************************

    logic [2:0] page_r;
    logic [6:0] col_r;

    // Addressing commands set page, low and high column parts
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            page_r <= 3'h0;
        end else if (!res_n_s) begin
            page_r <= 3'h0;
        end else if (is_cmd && byte_nxt[7:3] == `OSW_CMD_PAGE_TAG) begin
            page_r <= byte_nxt[2:0];
        end
    end

    // Column steps after each data byte and wraps within the page
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            col_r <= 7'h00;
        end else if (!res_n_s) begin
            col_r <= 7'h00;
        end else if (is_cmd && byte_nxt[7:4] == `OSW_CMD_COLLO_TAG) begin
            col_r[3:0] <= byte_nxt[3:0];
        end else if (is_cmd && byte_nxt[7:4] == `OSW_CMD_COLHI_TAG) begin
            col_r[6:4] <= byte_nxt[2:0];
        end else if (is_data) begin
            col_r <= col_r + 7'h01;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_PAGE <= 3'h0;
            O_COL <= 7'h00;
        end else begin
            O_PAGE <= page_r;
            O_COL <= col_r;
        end
    end

    // ********************************************
    // Display memory
    // ********************************************

    // 8 pages of 128 columns, one byte each: 1024 bytes
    logic [7:0] ram [0:`OSW_RAM_BYTES-1];
    osw_ram_addr_t wr_addr;
    osw_ram_addr_t rd_addr;
    logic [7:0] rd_byte;

    assign wr_addr = {page_r, col_r};

    // A byte covers 8 stacked rows of one column at once
    always_ff @(posedge I_CLOCK) begin
        if (is_data) ram[wr_addr] <= byte_nxt;
    end

    // Write echo for the panel driver
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WR_VALID <= 1'b0;
            O_WR_ADDR <= 10'h000;
            O_WR_DATA <= 8'h00;
        end else begin
            O_WR_VALID <= is_data;
            if (is_data) begin
                O_WR_ADDR <= wr_addr;
                O_WR_DATA <= byte_nxt;
            end
        end
    end

    // ********************************************
    // Pixel scan port
    // ********************************************

    // Row picks the page and bit, so each pixel is one stored bit
    // Memory has no reset: a scan before any write shows unknown pixels
    assign rd_addr = {I_PIX_Y[5:3], I_PIX_X};
    assign rd_byte = ram[rd_addr];

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) O_PIXEL <= 1'b0;
        else O_PIXEL <= rd_byte[I_PIX_Y[2:0]];
    end

endmodule
`default_nettype wire

// [osw_host.sv]
// Host end: queues user bytes in a FIFO and shifts them out in mode 0.
// Assumes the link joins osw_dev through osw_link_if; I_CLOCK is 250 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "osw_map.svh"

// ********************************************
// Byte FIFO
// ********************************************
module osw_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic ready_r;
    logic push;
    logic pop;

    // Ready leaves from its own flop so the user side sees no compare chain
    assign o_in_ready = ready_r;
    assign o_out_valid = (count_r != '0);
    assign o_out_data = mem[rd_ptr_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Storage has no reset; only the pointers define content
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end

    // Pointers wrap at DEPTH, which must be a power of two
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !pop) count_r <= count_r + 1'b1;
            else if (pop && !push) count_r <= count_r - 1'b1;
        end
    end

    // Ready is the next count compared one step ahead, so it tracks the count flop
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ready_r <= 1'b1;
        end else if (push && !pop) begin
            ready_r <= (count_r != (AW+1)'(DEPTH - 1));
        end else if (pop && !push) begin
            ready_r <= 1'b1;
        end
    end
endmodule

// ********************************************
// Host serialiser
// ********************************************
module osw_host
    import osw_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_TX_VALID,
    output logic O_TX_READY,
    input wire logic I_TX_DC,
    input wire logic [7:0] I_TX_BYTE,
    input wire logic I_FOUR_WIRE,
    input wire logic I_PANEL_RST,
    output logic O_BUSY,
    osw_link_if.host LNK
);
    localparam logic [3:0] HALF = 4'(`OSW_SCLK_HALF_CYC);
    osw_host_state_t state_r;
    logic [3:0] tmr_r;
    logic [3:0] bit_r;
    logic [8:0] sh_r;
    logic cs_n_r;
    logic sclk_r;
    logic ser_out_r;
    logic dc_r;
    logic res_n_r;
    logic busy_r;
    logic fifo_valid;
    logic fifo_pop;
    osw_word_t fifo_data;
    logic tmr_done;

    osw_fifo #(.WIDTH(9), .DEPTH(8)) u_fifo (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_in_valid(I_TX_VALID),
        .o_in_ready(O_TX_READY),
        .i_in_data({I_TX_DC, I_TX_BYTE}),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    // Pop only when starting a byte; a held panel reset stalls the queue
    assign fifo_pop = (state_r == OSW_H_IDLE) && fifo_valid && res_n_r;
    assign tmr_done = (tmr_r == HALF - 4'h1);

    assign LNK.cs_n = cs_n_r;
    assign LNK.sclk = sclk_r;
    assign LNK.serial_data_in = ser_out_r;
    assign LNK.dc = dc_r;
    assign LNK.res_n = res_n_r;
    assign O_BUSY = busy_r;

    // Panel reset pin follows the user request
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) res_n_r <= 1'b1;
        else res_n_r <= !I_PANEL_RST;
    end

    // Half-period divider makes the serial clock
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) tmr_r <= 4'h0;
        else if (state_r == OSW_H_IDLE || tmr_done) tmr_r <= 4'h0;
        else tmr_r <= tmr_r + 4'h1;
    end

    // Byte sequencer
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_r <= OSW_H_IDLE;
            cs_n_r <= 1'b1;
            sclk_r <= 1'b0;
            ser_out_r <= 1'b0;
            dc_r <= 1'b0;
            sh_r <= 9'h000;
            bit_r <= 4'h0;
            busy_r <= 1'b0;
        end else begin
            case (state_r)
                OSW_H_IDLE: begin
                    sclk_r <= 1'b0;
                    busy_r <= fifo_pop;
                    if (fifo_pop) begin
                        cs_n_r <= 1'b0;
                        dc_r <= fifo_data[8];
                        bit_r <= 4'h0;
                        // 3-wire sends the flag first, 4-wire MSB first
                        if (I_FOUR_WIRE) begin
                            sh_r <= {fifo_data[7:0], 1'b0};
                            ser_out_r <= fifo_data[7];
                        end else begin
                            sh_r <= fifo_data;
                            ser_out_r <= fifo_data[8];
                        end
                        state_r <= OSW_H_LOW;
                    end
                end
                OSW_H_LOW: begin
                    // Data has stood a half period before the rise
                    if (tmr_done) begin
                        sclk_r <= 1'b1;
                        state_r <= OSW_H_HIGH;
                    end
                end
                OSW_H_HIGH: begin
                    if (tmr_done) begin
                        sclk_r <= 1'b0;
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == (I_FOUR_WIRE ? `OSW_BYTE_BITS : `OSW_BITS_3W) - 4'h1) begin
                            state_r <= OSW_H_GAP;
                        end else begin
                            sh_r <= {sh_r[7:0], 1'b0};
                            ser_out_r <= sh_r[7];
                            state_r <= OSW_H_LOW;
                        end
                    end
                end
                OSW_H_GAP: begin
                    // Release select for a half period between bytes
                    cs_n_r <= 1'b1;
                    if (tmr_done) state_r <= OSW_H_IDLE;
                end
                default: begin
                    state_r <= OSW_H_IDLE;
                    cs_n_r <= 1'b1;
                    sclk_r <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [osw_link_if.sv]
// Pins of the serial write link between host and display controller.
// Assumes the host end drives every pin; the device only listens.
`timescale 1ns/1ps
`default_nettype none
interface osw_link_if;
    logic cs_n;   // Chip select, active low
    logic sclk;   // Serial clock, idles low
    logic serial_data_in; // Serial data, MSB first
    logic dc;     // Command/data flag pin, high means data
    logic res_n;  // Panel reset, active low
    modport host (output cs_n, output sclk, output serial_data_in, output dc, output res_n);
    modport dev (input cs_n, input sclk, input serial_data_in, input dc, input res_n);
endinterface
`default_nettype wire

// [osw_link_monitor.sv]
// Concurrent checks on the serial write link between the host and device ends.
// Assumes one sclk half period of 4 clocks, sampled on I_CLOCK.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Link checker
// ****************************************
module osw_link_monitor (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_FOUR_WIRE,
    input wire logic I_PANEL_RST,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_data_in,
    input wire logic dc,
    input wire logic res_n
);
    logic sclk_q_r;
    logic [3:0] rise_cnt_r;

    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    // Rises per frame; cleared while deselected so an aborted frame cannot leak
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sclk_q_r <= 1'b0;
            rise_cnt_r <= 4'h0;
        end else begin
            sclk_q_r <= sclk;
            if (cs_n) begin
                rise_cnt_r <= 4'h0;
            end else if (sclk && !sclk_q_r) begin
                rise_cnt_r <= rise_cnt_r + 4'h1;
            end
        end
    end

    // Clock rests low whenever the device is not selected
    sclk_idle_low_a: assert property (cs_n |-> !sclk)
        else $error("sclk not low while deselected");
    first_edge_rise_a: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
        else $error("first sclk edge of a frame is not a rise after 4 clocks");
    high_width_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("sclk high phase not 4 clocks");
    low_width_a: assert property (($fell(sclk) && !cs_n) |-> !sclk [*4])
        else $error("sclk low phase shorter than 4 clocks");
    data_stable_a: assert property ((sclk && $past(sclk)) |-> $stable(serial_data_in))
        else $error("serial data moved while sclk high");
    flag_pin_stable_a: assert property ((!cs_n && $past(!cs_n)) |-> $stable(dc))
        else $error("dc moved inside a frame");
    bit_count_a: assert property (($rose(cs_n) && res_n) |->
        (rise_cnt_r == (I_FOUR_WIRE ? 4'h8 : 4'h9)))
        else $error("wrong number of bits in a frame");
    select_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("chip select gap shorter than 4 clocks");
    panel_reset_a: assert property (1'b1 |=> (res_n == !$past(I_PANEL_RST)))
        else $error("panel reset pin does not follow request");
endmodule
`default_nettype wire

// [osw_map.svh]
// Constants of the serial write port of the OLED controller and its host end.
// Assumes inclusion by bare name from the package and both end modules.
// What this block does
// - 3-wire: flag bit precedes each byte
// - 4-wire: flag comes from dedicated pin
// - Bus ignored while chip select high
// - Flag low command, high display data
// - One bit per serial clock rising edge
// - Bytes are eight bits, MSB first
// - Host idles serial clock low
// - Capture on first edge, mode 0
// - One stored bit per pixel
// - Eight pages, eight rows, 128 columns
// - Display memory holds 1024 bytes
// - Host sets page, column low, column high
// - Data byte sets eight vertical pixels
// - Panel reset low clears bit count, page and column
`ifndef OSW_MAP_SVH
`define OSW_MAP_SVH

// ********************************************
// Geometry
// ********************************************
`define OSW_PAGES 8
`define OSW_COLS 128
`define OSW_RAM_BYTES 1024
`define OSW_BYTE_BITS 4'h8
`define OSW_BITS_3W 4'h9

// ********************************************
// Addressing commands
// ********************************************
`define OSW_CMD_PAGE_TAG 5'h16
`define OSW_CMD_COLLO_TAG 4'h0
`define OSW_CMD_COLHI_TAG 4'h1

// ********************************************
// Timing
// ********************************************
`define OSW_CLK_NS 4
`define OSW_SCLK_HALF_NS 16
`define OSW_SCLK_HALF_CYC ((`OSW_SCLK_HALF_NS + `OSW_CLK_NS - 1) / `OSW_CLK_NS)

`endif

// [osw_pkg.sv]
// Types shared by both ends of the serial write port.
// Assumes osw_map.svh on the include path.
`default_nettype none
`include "osw_map.svh"
package osw_pkg;
    // Host serialiser states, one-hot
    typedef enum logic [3:0] {
        OSW_H_IDLE = 4'h1,
        OSW_H_LOW = 4'h2,
        OSW_H_HIGH = 4'h4,
        OSW_H_GAP = 4'h8
    } osw_host_state_t;
    typedef logic [9:0] osw_ram_addr_t;
    typedef logic [8:0] osw_word_t;
endpackage
`default_nettype wire
